// file: hw/smr_regs.v
`timescale 1ns/100ps
`include "smr_defines.vh"

// Operation
// - Status read-only, read clears transient flags
// - Status bits 7 and 5 unused
// - Data error flag on CRC/internal fault
// - CRC faults re-assert the error flag
// - Init flag set until init done
// - Serial output mismatch sets flag
// - Axis offset limit sets axis flags
// - Reset flag set after any reset
// - Tick counter 8-bit, per 1024 cycles
// - Tick nominally every 128 us; 1024 cycles of the 200 MHz clock give 5.12 us
// - Offset correction registers read-only
// - Factory shadow CRC check sets error
// - Writable CRC checked only after lock
// - Supply monitor holds device in reset
// - Regulator failure sets reset flag
// - Ground loss acts as device reset
// - Three-write sequence triggers reset
// - Lock blocks configuration writes
module smr_regs #(
    parameter INIT_CYCLES = `SMR_INIT_CYCLES
) (
    input  wire         clk,
    input  wire         reset_n,
    input  wire         supply_ok,
    input  wire         ground_ok,
    input  wire         vreg_fail,
    input  wire         wr_en,
    input  wire         rd_en,
    input  wire [7:0]   addr,
    input  wire [7:0]   wdata,
    output reg  [7:0]   rdata_q,
    input  wire         miso_mismatch,
    input  wire         offset_limit_x,
    input  wire         offset_limit_y,
    input  wire         offcorr_valid,
    input  wire [7:0]   x_offset_correction_in,
    input  wire [7:0]   y_offset_correction_in,
    input  wire [23:0]  shadow_data,
    input  wire [2:0]   shadow_crc,
    input  wire         internal_fault,
    output reg          device_reset_q,
    output reg          end_of_init_lock_q
);
    // ------------------------------------------------------------
    // Synchronisers for pin-side monitors
    // ------------------------------------------------------------
    reg  [1:0]  sup_s_q;
    reg  [1:0]  gnd_s_q;
    reg  [1:0]  vrf_s_q;
    reg  [1:0]  miso_s_q;
    reg  [1:0]  ofx_s_q;
    reg  [1:0]  ofy_s_q;

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sup_s_q  <= 2'b00;
            gnd_s_q  <= 2'b00;
            vrf_s_q  <= 2'b00;
            miso_s_q <= 2'b00;
            ofx_s_q  <= 2'b00;
            ofy_s_q  <= 2'b00;
        end
        else
        begin
            sup_s_q  <= {sup_s_q[0], supply_ok};
            gnd_s_q  <= {gnd_s_q[0], ground_ok};
            vrf_s_q  <= {vrf_s_q[0], vreg_fail};
            miso_s_q <= {miso_s_q[0], miso_mismatch};
            ofx_s_q  <= {ofx_s_q[0], offset_limit_x};
            ofy_s_q  <= {ofy_s_q[0], offset_limit_y};
        end
    end

    // ------------------------------------------------------------
    // Internal reset sources
    // ------------------------------------------------------------
    reg         spi_reset_q;
    wire        int_reset;
    assign int_reset = !sup_s_q[1] || !gnd_s_q[1] || spi_reset_q;

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            device_reset_q <= 1'b1;
        else
            device_reset_q <= int_reset;
    end

    // ------------------------------------------------------------
    // Initialization sequencer
    // ------------------------------------------------------------
    localparam ST_RESET = 2'b00;
    localparam ST_INIT  = 2'b01;
    localparam ST_RUN   = 2'b10;
    reg  [1:0]  state_q;
    reg  [7:0]  init_cnt_q;
    wire        init_busy;
    assign init_busy = (state_q != ST_RUN);

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q    <= ST_RESET;
            init_cnt_q <= 8'h00;
        end
        else if (device_reset_q)
        begin
            state_q    <= ST_RESET;
            init_cnt_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                ST_RESET:
                    state_q <= ST_INIT;
                ST_INIT:
                begin
                    init_cnt_q <= init_cnt_q + 8'h01;
                    if (init_cnt_q == INIT_CYCLES[7:0] - 8'h01)
                        state_q <= ST_RUN;
                end
                ST_RUN:
                    state_q <= ST_RUN;
                default:
                    state_q <= ST_RESET;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Writable registers, reset sequence and lock
    // ------------------------------------------------------------
    reg  [7:0]  arm_q [0:3];
    reg  [2:0]  wcrc_q;
    reg  [1:0]  resseq_q;
    reg         rsvd_bad_q;
    wire        wr_ctrl;
    wire        arm_hit;
    integer     i;
    assign wr_ctrl = wr_en && (addr == `SMR_ADDR_CTRL);
    assign arm_hit = (addr >= `SMR_ADDR_ARM0) && (addr <= `SMR_ADDR_ARM3);

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (i = 0; i < 4; i = i + 1)
                arm_q[i] <= 8'h00;
            wcrc_q             <= `SMR_CRC_SEED;
            end_of_init_lock_q <= 1'b0;
            resseq_q           <= `SMR_RESSEQ_1;
            spi_reset_q        <= 1'b0;
            rsvd_bad_q         <= 1'b0;
        end
        else if (device_reset_q)
        begin
            for (i = 0; i < 4; i = i + 1)
                arm_q[i] <= 8'h00;
            wcrc_q             <= `SMR_CRC_SEED;
            end_of_init_lock_q <= 1'b0;
            resseq_q           <= `SMR_RESSEQ_1;
            spi_reset_q        <= 1'b0;
        end
        else
        begin
            if (wr_en && !end_of_init_lock_q)
            begin
                if (arm_hit)
                    arm_q[addr[1:0]] <= wdata;
                if (addr == `SMR_ADDR_CRC)
                    wcrc_q <= wdata[2:0];
                if (addr == `SMR_ADDR_CFG)
                    end_of_init_lock_q <= wdata[`SMR_CFG_END_OF_INIT_LOCK];
            end
            if (wr_en && ((addr == `SMR_ADDR_RSVD_A) || (addr == `SMR_ADDR_RSVD_B)))
                rsvd_bad_q <= rsvd_bad_q | (wdata != 8'h00);
            if (wr_ctrl)
            begin
                case (resseq_q)
                    `SMR_RESSEQ_1:
                        resseq_q <= ({wdata[`SMR_CTL_RES_HI], wdata[`SMR_CTL_RES_LO]} == 2'b00)
                                    ? `SMR_RESSEQ_2 : `SMR_RESSEQ_1;
                    `SMR_RESSEQ_2:
                        resseq_q <= ({wdata[`SMR_CTL_RES_HI], wdata[`SMR_CTL_RES_LO]} == 2'b11)
                                    ? `SMR_RESSEQ_3 : `SMR_RESSEQ_1;
                    `SMR_RESSEQ_3:
                    begin
                        resseq_q <= `SMR_RESSEQ_1;
                        if ({wdata[`SMR_CTL_RES_HI], wdata[`SMR_CTL_RES_LO]} == 2'b10)
                            spi_reset_q <= 1'b1;
                    end
                    default:
                        resseq_q <= `SMR_RESSEQ_1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // CRC checkers and tick counter
    // ------------------------------------------------------------
    wire        shadow_fault;
    wire        wr_fault;
    wire        pre_tick;
    reg  [7:0]  tick_cnt_q;
    reg         wr_fault_seen_q;
    reg         shadow_fault_seen_q;

    smr_crc3 #(.NBYTES(3)) u_shadow_crc (
        .clk      (clk),
        .reset_n  (reset_n),
        .enable   (!device_reset_q),
        .data     (shadow_data),
        .expected (shadow_crc),
        .fault_q  (shadow_fault)
    );

    smr_crc3 #(.NBYTES(4)) u_wr_crc (
        .clk      (clk),
        .reset_n  (reset_n),
        .enable   (end_of_init_lock_q),
        .data     ({arm_q[0], arm_q[1], arm_q[2], arm_q[3]}),
        .expected (wcrc_q),
        .fault_q  (wr_fault)
    );

    smr_prescaler #(.DIV(`SMR_PRESCALE), .WIDTH(10)) u_prescaler (
        .clk     (clk),
        .reset_n (reset_n),
        .tick_q  (pre_tick)
    );

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tick_cnt_q          <= 8'h00;
            wr_fault_seen_q     <= 1'b0;
            shadow_fault_seen_q <= 1'b0;
        end
        else
        begin
            if (pre_tick)
                tick_cnt_q <= tick_cnt_q + 8'h01;
            if (device_reset_q)
                wr_fault_seen_q <= 1'b0;
            else if (wr_fault)
                wr_fault_seen_q <= 1'b1;
            if (shadow_fault)
                shadow_fault_seen_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Status flags and offset correction capture
    // ------------------------------------------------------------
    reg  [7:0]  status_q;
    reg  [7:0]  offx_q;
    reg  [7:0]  offy_q;
    wire        st_rd;
    wire        ide_set;
    assign st_rd   = rd_en && (addr == `SMR_ADDR_STATUS);
    assign ide_set = wr_fault_seen_q || shadow_fault_seen_q || internal_fault;

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_q <= 8'h00;
            offx_q   <= 8'h00;
            offy_q   <= 8'h00;
        end
        else
        begin
            if (st_rd || device_reset_q)
                status_q <= 8'h00;
            status_q[`SMR_ST_INIT] <= init_busy;
            if (ide_set)
                status_q[`SMR_ST_IDE] <= 1'b1;
            if (miso_s_q[1])
                status_q[`SMR_ST_MISO] <= 1'b1;
            if (ofx_s_q[1])
                status_q[`SMR_ST_OFFX] <= 1'b1;
            if (ofy_s_q[1])
                status_q[`SMR_ST_OFFY] <= 1'b1;
            if ((state_q == ST_INIT) || vrf_s_q[1])
                status_q[`SMR_ST_RESET] <= 1'b1;
            if (offcorr_valid)
            begin
                offx_q <= x_offset_correction_in;
                offy_q <= y_offset_correction_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_q <= 8'h00;
        else if (rd_en)
        begin
            case (addr)
                `SMR_ADDR_STATUS: rdata_q <= {1'b0, status_q[6], 1'b0, status_q[4:0]};
                `SMR_ADDR_TICK:   rdata_q <= tick_cnt_q;
                `SMR_ADDR_OFFX:   rdata_q <= offx_q;
                `SMR_ADDR_OFFY:   rdata_q <= offy_q;
                `SMR_ADDR_CFG:    rdata_q <= {end_of_init_lock_q, 6'h00, rsvd_bad_q};
                `SMR_ADDR_CRC:    rdata_q <= {5'h00, wcrc_q};
                default:          rdata_q <= arm_hit ? arm_q[addr[1:0]] : 8'h00;
            endcase
        end
    end
endmodule // smr_regs

// file: hw/smr_defines.vh
`ifndef SMR_DEFINES_VH
`define SMR_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define SMR_ADDR_STATUS     8'h14
`define SMR_ADDR_TICK       8'h15
`define SMR_ADDR_OFFX       8'h16
`define SMR_ADDR_OFFY       8'h17
`define SMR_ADDR_RSVD_A     8'h1c
`define SMR_ADDR_RSVD_B     8'h1d
`define SMR_ADDR_CTRL       8'h0f
`define SMR_ADDR_CFG        8'h0e
`define SMR_ADDR_CRC        8'h1e
`define SMR_ADDR_ARM0       8'h10
`define SMR_ADDR_ARM3       8'h13

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define SMR_ST_RESET        0
`define SMR_ST_OFFX         1
`define SMR_ST_OFFY         2
`define SMR_ST_MISO         3
`define SMR_ST_INIT         4
`define SMR_ST_IDE          6

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define SMR_CFG_END_OF_INIT_LOCK     7
`define SMR_CTL_RES_HI      1
`define SMR_CTL_RES_LO      0
`define SMR_RESSEQ_1        2'b00
`define SMR_RESSEQ_2        2'b01
`define SMR_RESSEQ_3        2'b10

// ----------------------------------------------------------------
// CRC and timing
// ----------------------------------------------------------------
`define SMR_CRC_SEED        3'h7
`define SMR_CRC_POLY        3'h3
`define SMR_PRESCALE        1024
`define SMR_TICK_US         128
`define SMR_CLK_MHZ         200
`define SMR_INIT_CYCLES     16
`define SMR_SYNC_RESET      8'h00

`endif

// file: hw/smr_prescaler.v
`timescale 1ns/100ps
`include "smr_defines.vh"

// Divides the oscillator into a one-cycle tick enable
module smr_prescaler #(
    parameter DIV   = `SMR_PRESCALE,
    parameter WIDTH = 10
) (
    input  wire             clk,
    input  wire             reset_n,
    output reg              tick_q
);
    reg  [WIDTH-1:0]        cnt_q;

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q  <= {WIDTH{1'b0}};
            tick_q <= 1'b0;
        end
        else
        begin
            if (cnt_q == DIV[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1})
            begin
                cnt_q  <= {WIDTH{1'b0}};
                tick_q <= 1'b1;
            end
            else
            begin
                cnt_q  <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
                tick_q <= 1'b0;
            end
        end
    end
endmodule // smr_prescaler

// file: hw/smr_crc3.v
`timescale 1ns/100ps
`include "smr_defines.vh"

// Serial 3-bit CRC, x^3+x+1, seed 111, MSB first over N bytes
module smr_crc3 #(
    parameter NBYTES = 4
) (
    input  wire                 clk,
    input  wire                 reset_n,
    input  wire                 enable,
    input  wire [NBYTES*8-1:0]  data,
    input  wire [2:0]           expected,
    output reg                  fault_q
);
    localparam CW = 8;
    reg  [2:0]      crc_q;
    reg  [CW-1:0]   idx_q;
    wire            fb;
    wire [2:0]      crc_nx;
    wire            last;

    assign fb     = crc_q[2] ^ data[NBYTES*8-1-idx_q];
    assign crc_nx = {crc_q[1:0], 1'b0} ^ (fb ? `SMR_CRC_POLY : 3'h0);
    assign last   = (idx_q == NBYTES*8-1);

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            crc_q   <= `SMR_CRC_SEED;
            idx_q   <= {CW{1'b0}};
            fault_q <= 1'b0;
        end
        else if (!enable)
        begin
            crc_q   <= `SMR_CRC_SEED;
            idx_q   <= {CW{1'b0}};
            fault_q <= 1'b0;
        end
        else if (last)
        begin
            crc_q   <= `SMR_CRC_SEED;
            idx_q   <= {CW{1'b0}};
            fault_q <= (crc_nx != expected);
        end
        else
        begin
            crc_q   <= crc_nx;
            idx_q   <= idx_q + {{(CW-1){1'b0}}, 1'b1};
            fault_q <= 1'b0;
        end
    end
endmodule // smr_crc3

// file: sim/smr_regs_monitor.sv
`timescale 1ns/100ps
`include "smr_defines.vh"

// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module smr_regs_monitor #(
    parameter INIT_CYCLES = `SMR_INIT_CYCLES
) (
    input wire       clk,
    input wire       reset_n,
    input wire       supply_ok,
    input wire       ground_ok,
    input wire       wr_en,
    input wire       rd_en,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire [7:0] rdata_q,
    input wire       device_reset_q,
    input wire       end_of_init_lock_q
);
    reg [7:0] since_q;

    // Cycles since internal reset released, saturating
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            since_q <= 8'h00;
        else if (device_reset_q)
            since_q <= 8'h00;
        else if (since_q != 8'hff)
            since_q <= since_q + 8'h01;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    AST_RDATA_HOLD: assert property (!rd_en |=> $stable(rdata_q))
        else $error("read data changed without a read");
    AST_UNUSED_BITS: assert property (rd_en && addr == 8'h14 |=> rdata_q[7] == 1'b0 && rdata_q[5] == 1'b0)
        else $error("unused status bits not zero");
    AST_SUPPLY_HOLD: assert property (!supply_ok |-> ##[0:4] device_reset_q)
        else $error("supply loss did not reset");
    AST_RELEASE: assert property ($fell(device_reset_q) |-> $past(supply_ok, 2) && $past(ground_ok, 2))
        else $error("reset released with bad supply");
    AST_GROUND_LOSS: assert property (!ground_ok |-> ##[0:4] device_reset_q)
        else $error("ground loss did not reset");
    AST_RESET_SEQ: assert property (wr_en && addr == 8'h0f && wdata[1:0] == 2'b00 && !device_reset_q
        ##1 wr_en && addr == 8'h0f && wdata[1:0] == 2'b11
        ##1 wr_en && addr == 8'h0f && wdata[1:0] == 2'b10 |-> ##[1:3] device_reset_q)
        else $error("reset sequence ignored");
    AST_LOCK_CLEAR: assert property ($rose(device_reset_q) |-> ##[0:2] !end_of_init_lock_q)
        else $error("lock survived reset");
    AST_INIT_SET: assert property (rd_en && addr == 8'h14 && since_q >= 3 && since_q <= INIT_CYCLES - 4
        |=> rdata_q[4])
        else $error("init flag low during init");
    AST_INIT_CLR: assert property (rd_en && addr == 8'h14 && since_q > INIT_CYCLES + 8 |=> !rdata_q[4])
        else $error("init flag stuck high");
endmodule // smr_regs_monitor

bind smr_regs smr_regs_monitor #(.INIT_CYCLES(INIT_CYCLES)) i_mon (
    .clk                (clk),
    .reset_n            (reset_n),
    .supply_ok          (supply_ok),
    .ground_ok          (ground_ok),
    .wr_en              (wr_en),
    .rd_en              (rd_en),
    .addr               (addr),
    .wdata              (wdata),
    .rdata_q            (rdata_q),
    .device_reset_q     (device_reset_q),
    .end_of_init_lock_q (end_of_init_lock_q)
);

// file: sim/smr_host_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Serial master host, register access side
// ----------------------------------------------------------------
module smr_host_model (
    input  wire       clk,
    output reg        wr_en,
    output reg        rd_en,
    output reg  [7:0] addr,
    output reg  [7:0] wdata
);
    initial
    begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'hff;
        wdata = 8'hff;
    end

    // One strobe cycle, then lines show the inverse of the last value
    task access(input reg we, input reg [7:0] a, input reg [7:0] d);
        begin
            @(posedge clk);
            wr_en <= we;
            rd_en <= !we;
            addr <= a;
            wdata <= (a == 8'h1c || a == 8'h1d) ? 8'h00 : d;
            @(posedge clk);
            wr_en <= 1'b0;
            rd_en <= 1'b0;
            addr <= ~a;
            wdata <= ~d;
        end
    endtask

    // Three back-to-back control writes that request a reset
    task reset_seq;
        begin
            @(posedge clk);
            wr_en <= 1'b1;
            addr <= 8'h0f;
            wdata <= 8'h00;
            @(posedge clk);
            wdata <= 8'h03;
            @(posedge clk);
            wdata <= 8'h02;
            @(posedge clk);
            wr_en <= 1'b0;
            addr <= 8'hf0;
            wdata <= 8'hfd;
        end
    endtask
endmodule // smr_host_model

// file: sim/smr_regs_test.sv
`timescale 1ns/100ps

`define CHK(n, e, g) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin num_errors = num_errors + 1; \
    $display("MISMATCH reg_%h exp %h got %h", n, e, g); end end

// ----------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------
module smr_regs_test;
    reg         clk, reset_n, supply_ok, ground_ok, vreg_fail, internal_fault;
    reg         miso_mismatch, offset_limit_x, offset_limit_y, offcorr_valid;
    reg  [7:0]  x_offset_correction_in, y_offset_correction_in;
    reg  [23:0] shadow_data;
    reg  [2:0]  shadow_crc;
    wire        wr_en, rd_en, device_reset_q, end_of_init_lock_q;
    wire [7:0]  addr, wdata, rdata_q;
    reg  [31:0] rnd;
    reg  [23:0] e;
    reg         rd_d;
    integer     num_errors, cmp_count, cyc, i, p, k;
    reg  [23:0] exp_q[$];

    always #2.5 clk = ~clk;

    smr_host_model i_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata));

    smr_regs i_dut (
        .clk(clk), .reset_n(reset_n), .supply_ok(supply_ok), .ground_ok(ground_ok),
        .vreg_fail(vreg_fail), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
        .rdata_q(rdata_q), .miso_mismatch(miso_mismatch), .offset_limit_x(offset_limit_x),
        .offset_limit_y(offset_limit_y), .offcorr_valid(offcorr_valid), .x_offset_correction_in(x_offset_correction_in),
        .y_offset_correction_in(y_offset_correction_in), .shadow_data(shadow_data), .shadow_crc(shadow_crc),
        .internal_fault(internal_fault), .device_reset_q(device_reset_q),
        .end_of_init_lock_q(end_of_init_lock_q)
    );

    function [31:0] xs(input reg [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction

    // Serial check bits, x^3+x+1, seed 111, MSB first
    function [2:0] crc3(input reg [31:0] d, input integer n);
        reg [2:0] c;
        reg       fb;
        integer   j;
        begin
            c = 3'b111;
            for (j = n - 1; j >= 0; j = j - 1)
            begin
                fb = c[2] ^ d[j];
                c = {c[1], c[0] ^ fb, fb};
            end
            crc3 = c;
        end
    endfunction

    task print_verdict;
        begin
            $display("TB: comparisons %0d mismatches %0d", cmp_count, num_errors);
            if (num_errors == 0 && cmp_count > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    task rd(input reg [7:0] a, input reg [7:0] m, input reg [7:0] v);
        begin
            exp_q.push_back({a, m, v & m});
            i_host.access(1'b0, a, 8'h00);
        end
    endtask

    task wr(input reg [7:0] a, input reg [7:0] v);
        i_host.access(1'b1, a, v);
    endtask

    task idle(input integer n);
        repeat (n) @(posedge clk);
    endtask

    // Bounded wait for internal reset release, then step into the init window
    task wait_init;
        begin
            k = 0;
            while (device_reset_q !== 1'b0 && k < 300)
            begin
                @(posedge clk);
                k = k + 1;
            end
            if (k == 300)
            begin
                num_errors = num_errors + 1;
                print_verdict;
            end
            idle(3);
        end
    endtask

    // ------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        rd_d <= rd_en;
        cyc <= reset_n ? cyc + 1 : 0;
    end

    always @(negedge clk)
    begin
        if (rd_d === 1'b1 && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            `CHK(e[23:16], e[7:0], rdata_q & e[15:8])
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0; reset_n = 1'b0; num_errors = 0; cmp_count = 0;
        {vreg_fail, ground_ok, supply_ok} = 3'b011;
        {internal_fault, miso_mismatch, offset_limit_y, offset_limit_x, offcorr_valid} = 5'h00;
        rnd = xs(32'haf20);
        x_offset_correction_in = 8'h00; y_offset_correction_in = 8'h00; shadow_data = rnd[23:0];
        shadow_crc = crc3({8'h00, rnd[23:0]}, 24);
        idle(4);
        reset_n <= 1'b1;
        idle(1);
        wait_init;
        rd(8'h14, 8'h11, 8'h11);
        rd(8'h15, 8'hff, 8'h00);
        idle(40);
        rd(8'h14, 8'hff, 8'h01);
        while (cyc < 1500) @(posedge clk);
        rd(8'h15, 8'hff, 8'h01);
        while (cyc < 2600) @(posedge clk);
        rd(8'h15, 8'hff, 8'h02);
        $display("test 1 done");
        for (i = 0; i < 4; i = i + 1)
        begin
            @(posedge clk);
            {internal_fault, miso_mismatch, offset_limit_y, offset_limit_x} <= 4'h1 << i;
            idle(4);
            {internal_fault, miso_mismatch, offset_limit_y, offset_limit_x} <= 4'h0;
            idle(4);
            rd(8'h14, 8'h4e, (i == 3) ? 8'h40 : (8'h02 << i));
            rd(8'h14, 8'h4e, 8'h00);
        end
        $display("test 2 done");
        rnd = xs(rnd);
        @(posedge clk);
        {y_offset_correction_in, x_offset_correction_in, offcorr_valid} <= {rnd[15:0], 1'b1};
        @(posedge clk);
        {y_offset_correction_in, x_offset_correction_in, offcorr_valid} <= {~rnd[15:0], 1'b0};
        wr(8'h16, ~rnd[7:0]);
        wr(8'h1c, 8'hff);
        rd(8'h16, 8'hff, rnd[7:0]);
        rd(8'h17, 8'hff, rnd[15:8]);
        rd(8'h1c, 8'hff, 8'h00);
        rd(8'h0e, 8'h01, 8'h00);
        rd(8'h20, 8'hff, 8'h00);
        $display("test 3 done");
        for (p = 0; p < 2; p = p + 1)
        begin
            rnd = xs(rnd);
            for (i = 0; i < 4; i = i + 1)
                wr(8'h10 + i[7:0], rnd[8*i +: 8]);
            wr(8'h1e, {5'h00, crc3({rnd[7:0], rnd[15:8], rnd[23:16], rnd[31:24]}, 32) ^ p[2:0]});
            wr(8'h0e, 8'h80);
            idle(100);
            rd(8'h14, 8'h40, {1'b0, p[0], 6'h00});
            idle(100);
            rd(8'h14, 8'h40, {1'b0, p[0], 6'h00});
            wr(8'h10, ~rnd[7:0]);
            rd(8'h10, 8'hff, rnd[7:0]);
            rd(8'h0e, 8'h80, 8'h80);
            i_host.reset_seq;
            idle(4);
            wait_init;
            rd(8'h14, 8'h51, 8'h11);
        end
        $display("test 4 done");
        @(posedge clk);
        shadow_crc <= ~shadow_crc;
        idle(100);
        rd(8'h14, 8'h40, 8'h40);
        i_host.reset_seq;
        idle(4);
        wait_init;
        idle(40);
        rd(8'h14, 8'h51, 8'h41);
        shadow_crc <= ~shadow_crc;
        $display("test 5 done");
        for (i = 0; i < 3; i = i + 1)
        begin
            @(posedge clk);
            {vreg_fail, ground_ok, supply_ok} <= 3'b011 ^ (3'b001 << i);
            idle(8);
            {vreg_fail, ground_ok, supply_ok} <= 3'b011;
            idle(4);
            wait_init;
            idle(30);
            rd(8'h14, 8'h11, 8'h01);
        end
        $display("test 6 done");
        idle(4);
        print_verdict;
    end
endmodule // smr_regs_test
